//--- verilog/spid_core.sv
// Servo PID filter, host parallel port and motor output core
// Overview of operation
// - Saturate position error to signed 16 bits
// - Multiplies are 16x16, low 16 bits kept
// - Integral accumulates error to 24 bits
// - Top 16 integral bits shifted eight, times gain
// - Integral term magnitude clamped by limit
// - Derivative difference times gain each interval
// - New or held derivative product added every sample
// - Sum terms, output top 8 or 12
// - Command byte latched on write rising edge
// - Busy stays high at most 100 us
// - Status driven while read strobe low
// - Data words two bytes, high byte first
// - Command written while busy is dropped
// - Busy set after command or second byte
// - Output port latched 8 or muxed 12
// - Offset binary output, 80 or 800 zero
// - Phase and strobe signals for demultiplexing
// - Sign magnitude PWM direction and magnitude
// - Status read needs no command code
// - Sample every 2048 clocks, derivative 1-256
// - Reset clears coefficients, zero output, 8-bit
module spid_core (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    // Host port
    input  wire logic        PORT_SELECT_N,
    input  wire logic        RD_N,
    input  wire logic        WR_N,
    input  wire logic [7:0]  DATA_IN,
    output logic      [7:0]  DATA_OUT,
    output logic             DATA_OE,
    // Loop error input
    input  wire logic [31:0] POS_ERROR,
    // Converter port
    output logic      [7:0]  DAC_OUT,
    output logic             DAC_PHASE,
    output logic             DAC_STROBE,
    output logic             WIDE_MODE,
    // Pulse width output
    output logic             PWM_DIR,
    output logic             PWM_MAG,
    // Status
    output logic             BUSY
);

    function automatic logic [15:0] spid_abs16(input logic [15:0] v);
        spid_abs16 = v[15] ? ((v == spid_pkg::SAT_NEG) ? spid_pkg::SAT_POS : 16'(-v)) : v;
    endfunction : spid_abs16

    function automatic logic [15:0] spid_mul16(input logic [15:0] a, input logic [15:0] b);
        logic [31:0] p;
        p = 32'($signed(a) * $signed(b));
        spid_mul16 = p[15:0];
    endfunction : spid_mul16

    // State
    spid_pkg::spid_host_state_t   state_reg,   state_next;
    spid_pkg::spid_coef_t         coef_reg,    coef_next;
    spid_pkg::spid_coef_t         buf_reg,     buf_next;
    logic [spid_pkg::SAMPLE_W-1:0] samp_cnt_reg;
    logic [spid_pkg::BUSY_W-1:0]  busy_cnt_reg, busy_cnt_next;
    logic                         busy_reg,    busy_next;
    logic                         wr_prev_reg;
    logic                         rd_prev_reg;
    logic                         byte_hi_reg, byte_hi_next;
    logic [7:0]                   hi_byte_reg, hi_byte_next;
    logic [2:0]                   word_idx_reg, word_idx_next;
    logic                         wide_reg,    wide_next;
    logic                         clear_filt;
    logic [23:0]                  integ_reg;
    logic [15:0]                  prev_err_reg;
    logic [15:0]                  dprod_reg;
    logic [7:0]                   dcnt_reg;
    logic [15:0]                  sum_reg;
    logic [11:0]                  code_reg;
    logic [7:0]                   dac_reg;
    logic                         phase_reg;
    logic                         strobe_reg;
    logic [7:0]                   pwm_mag_reg;
    logic                         pwm_dir_reg;
    logic [7:0]                   pwm_cnt_reg;
    logic [7:0]                   dout_reg;
    logic [15:0]                  rd_snap_reg;
    logic                         sample_d_reg;
    logic                         pwm_out_reg;

    // Host strobe decode
    wire        wr_rise   = ~wr_prev_reg & WR_N;
    wire        rd_rise   = ~rd_prev_reg & RD_N;
    wire        cmd_wr    = wr_rise & ~PORT_SELECT_N;
    wire        cmd_take  = cmd_wr & ~busy_reg;
    wire        data_wr   = wr_rise & PORT_SELECT_N;
    wire        data_rd   = rd_rise & PORT_SELECT_N;
    wire        word_done = (data_wr | data_rd) & ~byte_hi_reg;
    wire [15:0] word_in   = {hi_byte_reg, DATA_IN};
    wire        sample    = (samp_cnt_reg == spid_pkg::SAMPLE_W'(spid_pkg::SAMPLE_CYCLES - 1));

    // Filter arithmetic
    wire        err_hi    = ~POS_ERROR[31] & (|POS_ERROR[30:15]);
    wire        err_lo    = POS_ERROR[31] & ~(&POS_ERROR[30:15]);
    wire [15:0] err16     = err_hi ? spid_pkg::SAT_POS :
                            err_lo ? spid_pkg::SAT_NEG : POS_ERROR[15:0];
    wire [23:0] integ_new = integ_reg + {{8{err16[15]}}, err16};
    wire [15:0] integ_top = integ_new[23:8];
    wire [15:0] integ_shf = 16'($signed(integ_top) >>> spid_pkg::INT_SHIFT);
    wire [15:0] iprod     = spid_mul16(integ_shf, coef_reg.integral_gain);
    wire [15:0] imag      = spid_abs16(iprod);
    wire [15:0] ilim      = spid_abs16(coef_reg.integration_limit);
    wire [15:0] imag_lim  = (imag < ilim) ? imag : ilim;
    wire [15:0] iterm     = iprod[15] ? 16'(-imag_lim) : imag_lim;
    wire [15:0] pprod     = spid_mul16(err16, coef_reg.proportional_gain);
    wire        d_take    = (dcnt_reg == coef_reg.deriv_interval);
    wire [15:0] ddiff     = 16'(err16 - prev_err_reg);
    wire [15:0] dnew      = spid_mul16(ddiff, coef_reg.derivative_gain);
    wire [15:0] dcur      = d_take ? dnew : dprod_reg;
    wire [15:0] sum_new   = 16'(pprod + iterm + dcur);
    wire [11:0] code_new  = wide_reg ? (sum_new[15:4] ^ spid_pkg::ZERO_CODE12)
                                     : {4'h0, sum_new[15:8] ^ spid_pkg::ZERO_CODE8};
    wire [15:0] sum_abs   = spid_abs16(sum_reg);
    wire [7:0]  half_out  = phase_reg ? {2'h0, code_reg[5:0]} : {2'h0, code_reg[11:6]};
    wire [7:0]  status    = {7'h00, busy_reg};

    // Host command and data sequencing
    always_comb begin
        state_next    = state_reg;
        coef_next     = coef_reg;
        buf_next      = buf_reg;
        byte_hi_next  = byte_hi_reg;
        hi_byte_next  = hi_byte_reg;
        word_idx_next = word_idx_reg;
        wide_next     = wide_reg;
        busy_next     = busy_reg;
        busy_cnt_next = busy_cnt_reg;
        clear_filt    = 1'b0;
        if (busy_reg) begin
            busy_cnt_next = 10'(busy_cnt_reg + 1'b1);
            if (busy_cnt_reg == spid_pkg::BUSY_W'(spid_pkg::BUSY_CYCLES - 1)) begin
                busy_next = 1'b0;
            end
        end
        if (data_wr | data_rd) begin
            byte_hi_next = ~byte_hi_reg;
            if (byte_hi_reg && data_wr) begin
                hi_byte_next = DATA_IN;
            end
        end
        if (word_done && state_reg == spid_pkg::SPID_CMD_DATA_WR) begin
            case (word_idx_reg)
                spid_pkg::WORD_DERIV_INT: buf_next.deriv_interval    = word_in[7:0];
                spid_pkg::WORD_PROP:      buf_next.proportional_gain = word_in;
                spid_pkg::WORD_INTEG:     buf_next.integral_gain     = word_in;
                spid_pkg::WORD_DERIV:     buf_next.derivative_gain   = word_in;
                spid_pkg::WORD_LIMIT:     buf_next.integration_limit = word_in;
                default:                  buf_next = buf_reg;
            endcase
        end
        if (word_done && word_idx_reg != 3'(spid_pkg::MAX_WORDS - 1)) begin
            word_idx_next = 3'(word_idx_reg + 1'b1);
        end
        if (word_done) begin
            busy_next     = 1'b1;
            busy_cnt_next = '0;
        end
        if (cmd_take) begin
            busy_next     = 1'b1;
            busy_cnt_next = '0;
            byte_hi_next  = 1'b1;
            word_idx_next = '0;
            state_next    = spid_pkg::SPID_IDLE;
            case (DATA_IN)
                spid_pkg::CMD_RESET: begin
                    coef_next  = spid_pkg::COEF_RESET;
                    buf_next   = spid_pkg::COEF_RESET;
                    wide_next  = 1'b0;
                    clear_filt = 1'b1;
                end
                spid_pkg::CMD_NARROW:       wide_next  = 1'b0;
                spid_pkg::CMD_WIDE:         wide_next  = 1'b1;
                spid_pkg::CMD_APPLY_FILTER: coef_next  = buf_reg;
                spid_pkg::CMD_LOAD_FILTER:  state_next = spid_pkg::SPID_CMD_DATA_WR;
                spid_pkg::CMD_READ_SUM:     state_next = spid_pkg::SPID_CMD_DATA_RD;
                default:                    state_next = spid_pkg::SPID_IDLE;
            endcase
        end
    end

    // Host side registers
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_reg    <= spid_pkg::SPID_IDLE;
            coef_reg     <= spid_pkg::COEF_RESET;
            buf_reg      <= spid_pkg::COEF_RESET;
            busy_reg     <= 1'b0;
            busy_cnt_reg <= '0;
            byte_hi_reg  <= 1'b1;
            hi_byte_reg  <= 8'h00;
            word_idx_reg <= 3'h0;
            wide_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            coef_reg     <= coef_next;
            buf_reg      <= buf_next;
            busy_reg     <= busy_next;
            busy_cnt_reg <= busy_cnt_next;
            byte_hi_reg  <= byte_hi_next;
            hi_byte_reg  <= hi_byte_next;
            word_idx_reg <= word_idx_next;
            wide_reg     <= wide_next;
        end
    end

    // Host strobe history
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wr_prev_reg <= 1'b1;
            rd_prev_reg <= 1'b1;
        end else begin
            wr_prev_reg <= WR_N;
            rd_prev_reg <= RD_N;
        end
    end

    // Integral snapshot so both read bytes match
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rd_snap_reg <= 16'h0000;
        end else if (byte_hi_reg && !data_rd) begin
            rd_snap_reg <= integ_reg[23:8];
        end
    end

    // Read data byte
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            dout_reg <= 8'h00;
        end else if (~PORT_SELECT_N) begin
            dout_reg <= status;
        end else begin
            dout_reg <= byte_hi_reg ? rd_snap_reg[15:8] : rd_snap_reg[7:0];
        end
    end

    // Base sample counter
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            samp_cnt_reg <= '0;
            sample_d_reg <= 1'b0;
        end else begin
            samp_cnt_reg <= spid_pkg::SAMPLE_W'(samp_cnt_reg + 1'b1);
            sample_d_reg <= sample & ~clear_filt;
        end
    end

    // Filter state
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            integ_reg    <= 24'h000000;
            prev_err_reg <= 16'h0000;
            dprod_reg    <= 16'h0000;
            dcnt_reg     <= 8'h00;
            sum_reg      <= 16'h0000;
            code_reg     <= {4'h0, spid_pkg::ZERO_CODE8};
        end else begin
            if (clear_filt) begin
                integ_reg    <= 24'h000000;
                prev_err_reg <= 16'h0000;
                dprod_reg    <= 16'h0000;
                dcnt_reg     <= 8'h00;
                sum_reg      <= 16'h0000;
                code_reg     <= {4'h0, spid_pkg::ZERO_CODE8};
            end else if (sample) begin
                integ_reg <= integ_new;
                sum_reg   <= sum_new;
                code_reg  <= code_new;
                dcnt_reg  <= d_take ? 8'h00 : 8'(dcnt_reg + 1'b1);
                if (d_take) begin
                    prev_err_reg <= err16;
                    dprod_reg    <= dnew;
                end
            end
        end
    end

    // Converter port
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            dac_reg    <= spid_pkg::ZERO_CODE8;
            phase_reg  <= 1'b0;
            strobe_reg <= 1'b0;
        end else if (wide_reg) begin
            phase_reg  <= ~phase_reg;
            dac_reg    <= half_out;
            strobe_reg <= phase_reg;
        end else begin
            phase_reg  <= 1'b0;
            dac_reg    <= code_reg[7:0];
            strobe_reg <= sample_d_reg;
        end
    end

    // Pulse width output
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pwm_mag_reg <= 8'h00;
            pwm_dir_reg <= 1'b0;
            pwm_cnt_reg <= 8'h00;
            pwm_out_reg <= 1'b0;
        end else begin
            pwm_cnt_reg <= 8'(pwm_cnt_reg + 1'b1);
            pwm_out_reg <= pwm_cnt_reg < pwm_mag_reg;
            if (clear_filt) begin
                pwm_dir_reg <= 1'b0;
                pwm_mag_reg <= 8'h00;
            end else if (sample_d_reg) begin
                pwm_dir_reg <= sum_reg[15];
                pwm_mag_reg <= sum_abs[14:7];
            end
        end
    end

    // Outputs
    assign DATA_OUT   = dout_reg;
    assign DATA_OE    = ~RD_N;
    assign DAC_OUT    = dac_reg;
    assign DAC_PHASE  = phase_reg;
    assign DAC_STROBE = strobe_reg;
    assign WIDE_MODE  = wide_reg;
    assign PWM_DIR    = pwm_dir_reg;
    assign PWM_MAG    = pwm_out_reg;
    assign BUSY       = busy_reg;

endmodule : spid_core

//--- verilog/spid_pkg.sv
// Package with constants and types of the servo PID host port core
package spid_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned BUSY_TIME_NS    = 20_000;
    localparam int unsigned BUSY_MAX_NS     = 100_000;
    localparam int unsigned BUSY_CYCLES     = (BUSY_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned SAMPLE_CYCLES   = 2048;
    localparam int unsigned SAMPLE_W        = 11;
    localparam int unsigned BUSY_W          = 10;
    localparam int unsigned MAX_WORDS       = 7;

    localparam logic [7:0]  CMD_RESET        = 8'h00;
    localparam logic [7:0]  CMD_START        = 8'h01;
    localparam logic [7:0]  CMD_APPLY_FILTER = 8'h04;
    localparam logic [7:0]  CMD_NARROW       = 8'h05;
    localparam logic [7:0]  CMD_WIDE         = 8'h06;
    localparam logic [7:0]  CMD_READ_SUM     = 8'h0D;
    localparam logic [7:0]  CMD_LOAD_FILTER  = 8'h1E;

    localparam int unsigned STAT_BUSY_BIT    = 0;
    localparam logic [7:0]  ZERO_CODE8       = 8'h80;
    localparam logic [11:0] ZERO_CODE12      = 12'h800;
    localparam logic [15:0] SAT_POS          = 16'h7FFF;
    localparam logic [15:0] SAT_NEG          = 16'h8000;
    localparam int unsigned INT_SHIFT        = 8;

    localparam logic [2:0]  WORD_DERIV_INT   = 3'h0;
    localparam logic [2:0]  WORD_PROP        = 3'h1;
    localparam logic [2:0]  WORD_INTEG       = 3'h2;
    localparam logic [2:0]  WORD_DERIV       = 3'h3;
    localparam logic [2:0]  WORD_LIMIT       = 3'h4;

    typedef struct packed {
        logic [7:0]  deriv_interval;
        logic [15:0] proportional_gain;
        logic [15:0] integral_gain;
        logic [15:0] derivative_gain;
        logic [15:0] integration_limit;
    } spid_coef_t;

    localparam spid_coef_t COEF_RESET = '0;

    typedef enum logic [1:0] {
        SPID_IDLE,
        SPID_CMD_DATA_WR,
        SPID_CMD_DATA_RD
    } spid_host_state_t;
endpackage : spid_pkg

//--- sim/spid_core_sva.sv
// Assertion checker for the servo PID host port core
module spid_core_sva (
    // Clock and reset
    input wire logic       SYS_CLK,
    input wire logic       RST,
    // Host port
    input wire logic       PORT_SELECT_N,
    input wire logic       RD_N,
    input wire logic       WR_N,
    input wire logic [7:0] DATA_OUT,
    input wire logic       DATA_OE,
    // Outputs
    input wire logic [7:0] DAC_OUT,
    input wire logic       DAC_PHASE,
    input wire logic       WIDE_MODE,
    input wire logic       BUSY
);
    logic        wr_reg;
    logic [12:0] busy_cnt_reg;
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wr_reg       <= 1'h1;
            busy_cnt_reg <= 13'h0000;
        end else begin
            wr_reg       <= WR_N;
            busy_cnt_reg <= BUSY ? busy_cnt_reg + 13'h0001 : 13'h0000;
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence cmd_taken;
        !wr_reg && WR_N && !PORT_SELECT_N;
    endsequence
    sequence status_read;
        !PORT_SELECT_N && !RD_N ##1 !PORT_SELECT_N && !RD_N;
    endsequence
    a_oe_follows_rd: assert property (DATA_OE == !RD_N)
        else $error("output enable does not follow read strobe");
    a_status_busy_bit: assert property (status_read |-> DATA_OUT == {7'h00, $past(BUSY)})
        else $error("status byte does not carry busy");
    a_busy_after_cmd: assert property (cmd_taken ##0 !BUSY |=> BUSY)
        else $error("busy not set after command");
    a_cmd_busy_drop: assert property (cmd_taken ##0 BUSY |=> $stable(WIDE_MODE))
        else $error("command acted on while busy");
    a_busy_bounded: assert property (BUSY |-> busy_cnt_reg < 13'h1388)
        else $error("busy held too long");
    a_busy_min_span: assert property ($rose(BUSY) |-> BUSY [*8])
        else $error("busy pulse too short");
    a_narrow_no_phase: assert property (!WIDE_MODE && $past(!WIDE_MODE) |-> !DAC_PHASE)
        else $error("phase moves in narrow mode");
    a_wide_phase_toggle: assert property (WIDE_MODE && $past(WIDE_MODE) |-> DAC_PHASE != $past(DAC_PHASE))
        else $error("phase does not alternate in wide mode");
    a_wide_upper_clear: assert property (WIDE_MODE && $past(WIDE_MODE, 2) |-> DAC_OUT[7:6] == 2'h0)
        else $error("wide half uses top bits");
    a_reset_zero_code: assert property (disable iff (1'h0) RST |-> DAC_OUT == 8'h80 && !WIDE_MODE && !BUSY)
        else $error("reset output state wrong");
endmodule : spid_core_sva

//--- sim/spid_host.sv
// Host processor model driving the parallel command and data port
module spid_host (
    // Clock
    input wire logic       SYS_CLK,
    // From the core
    input wire logic [7:0] DATA_OUT,
    // To the core
    output logic           PORT_SELECT_N,
    output logic           RD_N,
    output logic           WR_N,
    output logic [7:0]     DATA_IN
);
    initial begin
        PORT_SELECT_N = 1'h1;
        RD_N          = 1'h1;
        WR_N          = 1'h1;
        DATA_IN       = 8'h00;
    end
    task automatic put_byte(input logic sel_n, input logic [7:0] b);
        @(negedge SYS_CLK);
        PORT_SELECT_N = sel_n;
        DATA_IN       = b;
        WR_N          = 1'h0;
        @(negedge SYS_CLK);
        WR_N = 1'h1;
        @(negedge SYS_CLK);
        DATA_IN = ~b;
    endtask : put_byte
    task automatic read_status(output logic [7:0] s);
        @(negedge SYS_CLK);
        PORT_SELECT_N = 1'h0;
        RD_N          = 1'h0;
        repeat (2) @(negedge SYS_CLK);
        s    = DATA_OUT;
        RD_N = 1'h1;
    endtask : read_status
    task automatic wait_ready;
        logic [7:0] s;
        for (int i = 0; i < 2000; i++) begin
            read_status(s);
            if (s[0] === 1'h0) break;
        end
    endtask : wait_ready
    task automatic write_cmd(input logic [7:0] c);
        wait_ready();
        put_byte(1'h0, c);
    endtask : write_cmd
    task automatic write_word(input logic [15:0] w);
        wait_ready();
        put_byte(1'h1, w[15:8]);
        put_byte(1'h1, w[7:0]);
    endtask : write_word
endmodule : spid_host

//--- sim/spid_core_tb_top.sv
// Testbench top for the servo PID host port core
`define CHK(name, exp, got) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("FAIL %s expected %h seen %h", name, exp, got); end end
module spid_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk;
    logic        rst;
    logic        port_select_n, rd_n, wr_n, data_oe, dac_phase, dac_strobe;
    logic        wide_mode, pwm_dir, pwm_mag, busy;
    logic [7:0]  data_in, data_out, dac_out;
    logic [31:0] pos_error;
    int          error_cnt = 0;
    int          cmp_count = 0;
    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    spid_core u_spid_core (.SYS_CLK(sys_clk), .RST(rst), .PORT_SELECT_N(port_select_n),
        .RD_N(rd_n), .WR_N(wr_n), .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE(data_oe),
        .POS_ERROR(pos_error), .DAC_OUT(dac_out), .DAC_PHASE(dac_phase),
        .DAC_STROBE(dac_strobe), .WIDE_MODE(wide_mode), .PWM_DIR(pwm_dir),
        .PWM_MAG(pwm_mag), .BUSY(busy));
    spid_host u_spid_host (.SYS_CLK(sys_clk), .DATA_OUT(data_out),
        .PORT_SELECT_N(port_select_n), .RD_N(rd_n), .WR_N(wr_n), .DATA_IN(data_in));
    function automatic logic [15:0] sat16(input logic [31:0] e);
        if ($signed(e) > 32'sh0000_7FFF) return 16'h7FFF;
        if ($signed(e) < -32'sh0000_8000) return 16'h8000;
        return e[15:0];
    endfunction : sat16
    task automatic summarize;
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    task automatic t_reset_state;
        logic [7:0] s;
        `CHK("dac zero", 8'h80, dac_out)
        `CHK("wide mode", 1'h0, wide_mode)
        u_spid_host.read_status(s);
        `CHK("status", 8'h00, s)
    endtask : t_reset_state
    task automatic t_busy_time;
        int n;
        n = 0;
        u_spid_host.write_cmd(spid_pkg::CMD_START);
        while (busy !== 1'h0 && n < 6000) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK("busy cycles", spid_pkg::BUSY_CYCLES, n)
        `CHK("busy within limit", 1'h1, n * 20 <= 100000)
    endtask : t_busy_time
    task automatic t_wide_ignore;
        logic [7:0] a;
        u_spid_host.write_cmd(spid_pkg::CMD_WIDE);
        u_spid_host.put_byte(1'h0, spid_pkg::CMD_NARROW);
        @(negedge sys_clk);
        `CHK("wide kept", 1'h1, wide_mode)
        repeat (2100) @(negedge sys_clk);
        a = dac_out;
        @(negedge sys_clk);
        `CHK("wide halves", 8'h20, a ^ dac_out)
        u_spid_host.write_cmd(spid_pkg::CMD_RESET);
        repeat (2100) @(negedge sys_clk);
        `CHK("narrow again", 1'h0, wide_mode)
        `CHK("zero code", 8'h80, dac_out)
    endtask : t_wide_ignore
    task automatic t_filter;
        logic [31:0] errs [4] = '{32'h0000_0023, 32'h0000_1234, 32'h0001_0000, 32'hFFFE_0000};
        logic [15:0] p;
        logic [15:0] q;
        int          h;
        u_spid_host.write_cmd(spid_pkg::CMD_LOAD_FILTER);
        u_spid_host.write_word(16'h0000);
        u_spid_host.write_word(16'h0100);
        u_spid_host.write_cmd(spid_pkg::CMD_APPLY_FILTER);
        foreach (errs[i]) begin
            pos_error = errs[i];
            repeat (4200) @(negedge sys_clk);
            p = sat16(errs[i]) * 16'h0100;
            `CHK("filter code", p[15:8] ^ 8'h80, dac_out)
            `CHK("pwm sign", p[15], pwm_dir)
            q = p[15] ? 16'(-p) : p;
            h = 0;
            repeat (256) begin
                @(negedge sys_clk);
                h += pwm_mag;
            end
            `CHK("pwm duty", q[14:7], h[7:0])
        end
    endtask : t_filter
    initial begin
        rst       = 1'h1;
        pos_error = 32'h0000_0000;
        repeat (4) @(negedge sys_clk);
        t_reset_state();
        rst = 1'h0;
        @(negedge sys_clk);
        t_busy_time();
        t_wide_ignore();
        t_filter();
        summarize();
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        error_cnt++;
        summarize();
    end
endmodule : spid_core_tb_top
bind spid_core spid_core_sva u_spid_core_sva (.SYS_CLK(SYS_CLK), .RST(RST),
    .PORT_SELECT_N(PORT_SELECT_N), .RD_N(RD_N), .WR_N(WR_N), .DATA_OUT(DATA_OUT),
    .DATA_OE(DATA_OE), .DAC_OUT(DAC_OUT), .DAC_PHASE(DAC_PHASE), .WIDE_MODE(WIDE_MODE),
    .BUSY(BUSY));
